// ---- pkg/fir_bank_defs.svh ----
/*
  Offsets, field positions, reset values and timing counts of the banked infrared
  control registers. Assumes a 125 MHz system clock.
*/
`ifndef FIR_BANK_DEFS_SVH
`define FIR_BANK_DEFS_SVH

`define FIR_CLK_MHZ 125
`define FIR_BANK_RX 2'h1
`define FIR_BANK_IR 2'h2
// Bank 1 offsets
`define FIR_OFF_RFP_LO 3'h4
`define FIR_OFF_RFP_HI 3'h5
`define FIR_OFF_TXC_LO 3'h6
`define FIR_OFF_TXC_HI 3'h7
// Bank 2 offsets
`define FIR_OFF_CFG1 3'h1
`define FIR_OFF_XCVR 3'h2
`define FIR_OFF_CFG2 3'h3
`define FIR_OFF_TIMER 3'h4
`define FIR_OFF_CFG3 3'h5
// Field positions
`define FIR_XCVR_FREQ 5
`define FIR_XCVR_MODE 4
`define FIR_XCVR_ECHO 3
`define FIR_CFG2_AUTOCHOP_ENABLE 7
`define FIR_CFG2_CTL1 3
`define FIR_CFG2_CTL0 2
`define FIR_CFG2_SIRM 1
`define FIR_CFG2_FIRM 0
`define FIR_CFG3_CDEN 7
`define FIR_CFG3_CD 6
`define FIR_CFG3_TMEN 1
`define FIR_CFG3_TM 0
// Reset values
`define FIR_RFP_RST 16'h0000
`define FIR_CFG_RST 8'h00
// Timing
`define FIR_TICK_US 128
`define FIR_TICK_CYCLES (`FIR_TICK_US * `FIR_CLK_MHZ)
`define FIR_NS_CEIL(ns) (((ns) * `FIR_CLK_MHZ + 999) / 1000)
`define FIR_NS_FLOOR(ns) (((ns) * `FIR_CLK_MHZ) / 1000)
`define FIR_CHOP1_SINGLE_NS 187
`define FIR_CHOP1_PAIR_NS 209
`define FIR_CHOP2_SINGLE_NS 229
`define FIR_CHOP2_PAIR_NS 249
`define FIR_CHOP3_SINGLE_NS 208
`define FIR_CHOP3_PAIR_NS 229
`define FIR_AUTO_WIDE_NS 62
`define FIR_AUTO_NARROW_NS 42

`endif

// ---- pkg/fir_bank_pkg.sv ----
/*
  Types of the banked infrared register block. Assumes fir_bank_defs.svh for numbers.
*/
package fir_bank_pkg;
  typedef enum logic [3:0] {
    MOD_SERIAL_IR = 4'h0,
    MOD_ASK = 4'h1,
    MOD_FAST_1M = 4'h2,
    MOD_RESERVED = 4'h3,
    MOD_FAST_4M = 4'h4
  } ir_modulation_e;
  typedef enum logic [3:0] {
    SPEED_1152K = 4'h0,
    SPEED_576K = 4'h1,
    SPEED_288K = 4'h2
  } ir_speed_e;
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN = 2'b10
  } timer_state_e;
endpackage : fir_bank_pkg

// ---- pkg/fir_timer_if.sv ----
/*
  Carrier between the register block and its down timer. No assumptions beyond one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface fir_timer_if;
  logic load;
  logic [7:0] load_value;
  logic expire;
  logic [7:0] count;
  modport ctrl (output load, output load_value, input expire, input count);
  modport timer (input load, input load_value, output expire, output count);
endinterface : fir_timer_if
`default_nettype wire

// ---- hdl/sticky_flag.sv ----
/*
  One status flag set by hardware and cleared by writing one. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  // Set wins so an event in the clearing cycle is not lost
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end
endmodule : sticky_flag
`default_nettype wire

// ---- hdl/tick_down_timer.sv ----
/*
  Down counter decremented once per tick period, pulsing expire on reaching zero.
  Assumes loads come from the register block through the timer interface.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_down_timer
  import fir_bank_pkg::*;
#(
  parameter int TICK_CYCLES = 16000
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  fir_timer_if.timer tmr
);
  timer_state_e state;
  logic [15:0] prescale;
  logic [7:0] count;

  assign tmr.count = count;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= TMR_IDLE;
      prescale <= 16'h0000;
      count <= 8'h00;
      tmr.expire <= 1'b0;
    end else begin
      tmr.expire <= 1'b0;
      case (state)
        TMR_IDLE: begin
          if (tmr.load) begin
            count <= tmr.load_value;
            prescale <= 16'h0000;
            state <= TMR_RUN;
          end
        end
        TMR_RUN: begin
          if (tmr.load) begin
            count <= tmr.load_value;
            prescale <= 16'h0000;
          end else if (count == 8'h00) begin
            tmr.expire <= 1'b1;
            state <= TMR_IDLE;
          end else if (prescale == 16'(TICK_CYCLES - 1)) begin
            prescale <= 16'h0000;
            count <= count - 8'h01;
          end else begin
            prescale <= prescale + 16'h0001;
          end
        end
        default: state <= TMR_IDLE;
      endcase
    end
  end
endmodule : tick_down_timer
`default_nettype wire

// ---- hdl/fir_bank_regs.sv ----
/*
  Banked control and status registers of a fast infrared serial controller.
  Assumes the bank select, the DMA engine, the transmit FIFO and the receive
  demodulator live outside and present synchronous pulses and levels.
*/
// Local design decision: the plain strobed port.
// Functional notes
// - Read-only 16-bit end-of-packet pointer, two bytes
// - End-of-packet pointer resets to zero
// - Loaded 13-bit transmit count decrements per byte
// - No DMA requests once count is zero
// - Keep sending until transmit FIFO empties
// - Speed field selects one-megabit class rate
// - Modulation field selects infrared scheme
// - First style: frequency bit picks band pin
// - Second style: mode bit drives high pin
// - Echo bit enables loopback, resets clear
// - Autochop measures preamble pulse, sets level
// - Fixed chop settings give fixed thresholds
// - Autochop settings add margin to sample
// - Chop bits reset to zero, chopping off
// - Mask bits suppress serial and fast requests
// - Timer loads counter ticking every 128 us
// - Carrier detect sticky, write one clears
// - Timer pending sticky, write one clears, enabled
`include "fir_bank_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fir_bank_regs
  import fir_bank_pkg::*;
#(
  parameter int TICK_CYCLES = `FIR_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_bank,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx_eop,
  input wire logic [15:0] i_rx_eop_ptr,
  input wire logic i_tx_enable,
  input wire logic i_tx_byte_taken,
  input wire logic i_tx_fifo_full,
  input wire logic i_tx_fifo_empty,
  output logic o_tx_dma_req,
  output logic o_tx_send,
  output logic [3:0] o_ir_speed,
  output logic [3:0] o_ir_modulation,
  input wire logic i_xcvr_second_style,
  output logic o_low_band_rx_pin,
  output logic o_high_band_rx_pin,
  output logic o_echo,
  input wire logic i_rx_pulse,
  input wire logic i_in_preamble,
  output logic o_chop_on,
  output logic [7:0] o_chop_single_cycles,
  output logic [7:0] o_chop_pair_cycles,
  input wire logic i_sir_irq_req,
  output logic o_sir_irq,
  input wire logic i_carrier_seen,
  output logic o_fir_irq
);
  localparam logic [7:0] CH1_S = 8'(`FIR_NS_FLOOR(`FIR_CHOP1_SINGLE_NS));
  localparam logic [7:0] CH1_P = 8'(`FIR_NS_CEIL(`FIR_CHOP1_PAIR_NS));
  localparam logic [7:0] CH2_S = 8'(`FIR_NS_FLOOR(`FIR_CHOP2_SINGLE_NS));
  localparam logic [7:0] CH2_P = 8'(`FIR_NS_CEIL(`FIR_CHOP2_PAIR_NS));
  localparam logic [7:0] CH3_S = 8'(`FIR_NS_FLOOR(`FIR_CHOP3_SINGLE_NS));
  localparam logic [7:0] CH3_P = 8'(`FIR_NS_CEIL(`FIR_CHOP3_PAIR_NS));
  localparam logic [7:0] AUTO_WIDE = 8'(`FIR_NS_CEIL(`FIR_AUTO_WIDE_NS));
  localparam logic [7:0] AUTO_NARROW = 8'(`FIR_NS_CEIL(`FIR_AUTO_NARROW_NS));

  logic [15:0] end_packet_pointer;
  logic [12:0] tx_count;
  logic [7:0] ir_speed_modulation_config;
  logic [2:0] transceiver_control;
  logic autochop_enable;
  logic chop_ctrl_hi;
  logic chop_ctrl_lo;
  logic sir_mask;
  logic fir_mask;
  logic [7:0] down_timer_value;
  logic cd_irq_enable;
  logic timer_irq_enable;
  logic carrier_flag;
  logic timer_flag;
  logic pulse_prev;
  logic [7:0] pulse_width;
  logic [7:0] pulse_sample;
  logic [7:0] next_rdata;
  logic [7:0] next_single;
  logic [7:0] next_pair;
  logic bank_rx;
  logic bank_ir;
  logic wr_cfg3;

  fir_timer_if tmr_bus ();

  assign bank_rx = (i_bank == `FIR_BANK_RX);
  assign bank_ir = (i_bank == `FIR_BANK_IR);
  assign wr_cfg3 = i_wr && bank_ir && (i_addr == `FIR_OFF_CFG3);
  assign tmr_bus.load = i_wr && bank_ir && (i_addr == `FIR_OFF_TIMER);
  assign tmr_bus.load_value = i_wdata;

  tick_down_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .tmr(tmr_bus)
  );

  sticky_flag u_carrier_flag (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_set(i_carrier_seen),
    .i_clear(wr_cfg3 && i_wdata[`FIR_CFG3_CD]),
    .o_flag(carrier_flag)
  );

  sticky_flag u_timer_flag (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_set(tmr_bus.expire),
    .i_clear(wr_cfg3 && i_wdata[`FIR_CFG3_TM]),
    .o_flag(timer_flag)
  );

  // End-of-packet pointer, captured at each packet end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      end_packet_pointer <= `FIR_RFP_RST;
    end else if (i_rx_eop) begin
      end_packet_pointer <= i_rx_eop_ptr;
    end
  end

  // A software write beats a same-cycle decrement so a reload is never corrupted
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_count <= 13'h0000;
    end else if (i_wr && bank_rx && i_addr == `FIR_OFF_TXC_LO) begin
      tx_count[7:0] <= i_wdata;
    end else if (i_wr && bank_rx && i_addr == `FIR_OFF_TXC_HI) begin
      tx_count[12:8] <= i_wdata[4:0];
    end else if (i_tx_byte_taken && tx_count != 13'h0000) begin
      tx_count <= tx_count - 13'h0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_tx_dma_req <= 1'b0;
      o_tx_send <= 1'b0;
    end else begin
      o_tx_dma_req <= i_tx_enable && !i_tx_fifo_full && tx_count != 13'h0000;
      o_tx_send <= i_tx_enable && !i_tx_fifo_empty;
    end
  end

  // Bank 2 configuration
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ir_speed_modulation_config <= `FIR_CFG_RST;
      transceiver_control <= 3'h0;
      autochop_enable <= 1'b0;
      chop_ctrl_hi <= 1'b0;
      chop_ctrl_lo <= 1'b0;
      sir_mask <= 1'b0;
      fir_mask <= 1'b0;
      down_timer_value <= `FIR_CFG_RST;
      cd_irq_enable <= 1'b0;
      timer_irq_enable <= 1'b0;
    end else if (i_wr && bank_ir) begin
      case (i_addr)
        `FIR_OFF_CFG1: ir_speed_modulation_config <= i_wdata;
        `FIR_OFF_XCVR: transceiver_control <= i_wdata[5:3];
        `FIR_OFF_CFG2: begin
          autochop_enable <= i_wdata[`FIR_CFG2_AUTOCHOP_ENABLE];
          chop_ctrl_hi <= i_wdata[`FIR_CFG2_CTL1];
          chop_ctrl_lo <= i_wdata[`FIR_CFG2_CTL0];
          sir_mask <= i_wdata[`FIR_CFG2_SIRM];
          fir_mask <= i_wdata[`FIR_CFG2_FIRM];
        end
        `FIR_OFF_TIMER: down_timer_value <= i_wdata;
        `FIR_OFF_CFG3: begin
          cd_irq_enable <= i_wdata[`FIR_CFG3_CDEN];
          timer_irq_enable <= i_wdata[`FIR_CFG3_TMEN];
        end
        default: ;
      endcase
    end
  end

  // Speed and modulation drive the modem directly; reserved codes pass unchanged
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_ir_speed <= SPEED_1152K;
      o_ir_modulation <= MOD_SERIAL_IR;
    end else begin
      o_ir_speed <= ir_speed_modulation_config[7:4];
      o_ir_modulation <= ir_speed_modulation_config[3:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_low_band_rx_pin <= 1'b0;
      o_high_band_rx_pin <= 1'b0;
      o_echo <= 1'b0;
    end else begin
      o_echo <= transceiver_control[`FIR_XCVR_ECHO - 3];
      if (i_xcvr_second_style) begin
        o_low_band_rx_pin <= 1'b0;
        o_high_band_rx_pin <= transceiver_control[`FIR_XCVR_MODE - 3];
      end else begin
        o_low_band_rx_pin <= transceiver_control[`FIR_XCVR_FREQ - 3];
        o_high_band_rx_pin <= !transceiver_control[`FIR_XCVR_FREQ - 3];
      end
    end
  end

  // Preamble pulse sampling; width saturates so a stuck line cannot wrap
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pulse_prev <= 1'b0;
      pulse_width <= 8'h00;
      pulse_sample <= 8'h00;
    end else begin
      pulse_prev <= i_rx_pulse;
      if (i_rx_pulse) begin
        pulse_width <= (pulse_width == 8'hff) ? pulse_width : pulse_width + 8'h01;
      end else begin
        pulse_width <= 8'h00;
      end
      if (pulse_prev && !i_rx_pulse && i_in_preamble && autochop_enable) begin
        pulse_sample <= pulse_width;
      end
    end
  end

  always_comb begin
    next_single = 8'h00;
    next_pair = 8'h00;
    case ({autochop_enable, chop_ctrl_hi, chop_ctrl_lo})
      3'b001: begin
        next_single = CH1_S;
        next_pair = CH1_P;
      end
      3'b010: begin
        next_single = CH2_S;
        next_pair = CH2_P;
      end
      3'b011: begin
        next_single = CH3_S;
        next_pair = CH3_P;
      end
      3'b100: begin
        next_single = pulse_sample;
        next_pair = pulse_sample + AUTO_WIDE;
      end
      3'b101, 3'b110: begin
        next_single = pulse_sample;
        next_pair = pulse_sample + AUTO_NARROW;
      end
      3'b111: begin
        next_single = pulse_sample;
        next_pair = pulse_sample + 8'h01;
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_chop_on <= 1'b0;
      o_chop_single_cycles <= 8'h00;
      o_chop_pair_cycles <= 8'h00;
    end else begin
      o_chop_on <= autochop_enable || chop_ctrl_hi || chop_ctrl_lo;
      o_chop_single_cycles <= next_single;
      o_chop_pair_cycles <= next_pair;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_sir_irq <= 1'b0;
      o_fir_irq <= 1'b0;
    end else begin
      o_sir_irq <= i_sir_irq_req && !sir_mask;
      o_fir_irq <= !fir_mask && ((carrier_flag && cd_irq_enable) ||
                   (timer_flag && timer_irq_enable));
    end
  end

  // Register read mux; unmapped offsets and banks read zero
  always_comb begin
    next_rdata = 8'h00;
    if (bank_rx) begin
      case (i_addr)
        `FIR_OFF_RFP_LO: next_rdata = end_packet_pointer[7:0];
        `FIR_OFF_RFP_HI: next_rdata = end_packet_pointer[15:8];
        `FIR_OFF_TXC_LO: next_rdata = tx_count[7:0];
        `FIR_OFF_TXC_HI: next_rdata = {3'h0, tx_count[12:8]};
        default: next_rdata = 8'h00;
      endcase
    end else if (bank_ir) begin
      case (i_addr)
        `FIR_OFF_CFG1: next_rdata = ir_speed_modulation_config;
        `FIR_OFF_XCVR: next_rdata = {2'h0, transceiver_control, 3'h0};
        `FIR_OFF_CFG2: next_rdata = {autochop_enable, 3'h0, chop_ctrl_hi, chop_ctrl_lo,
                                     sir_mask, fir_mask};
        `FIR_OFF_TIMER: next_rdata = down_timer_value;
        `FIR_OFF_CFG3: next_rdata = {cd_irq_enable, carrier_flag, 4'h0,
                                     timer_irq_enable, timer_flag};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_read_rfp_lo;
    i_rd && bank_rx && i_addr == `FIR_OFF_RFP_LO;
  endsequence
  sequence s_cfg1_write;
    i_wr && bank_ir && i_addr == `FIR_OFF_CFG1;
  endsequence
  sequence s_expire_seen;
    tmr_bus.expire;
  endsequence

  a_rfp_capture: assert property (i_rx_eop |=> end_packet_pointer == $past(i_rx_eop_ptr))
    else $error("End pointer not captured");
  a_rfp_reset: assert property (disable iff (1'b0) $fell(i_sys_rst) |-> end_packet_pointer == 16'h0000)
    else $error("End pointer not zero after reset");
  a_tx_decrement: assert property (i_tx_byte_taken && !i_wr && tx_count != 13'h0000
    |=> tx_count == $past(tx_count) - 13'h0001)
    else $error("Transmit count did not decrement");
  a_dma_stop: assert property (tx_count == 13'h0000 |=> !o_tx_dma_req)
    else $error("DMA request with zero count");
  a_tx_drain: assert property (i_tx_enable && !i_tx_fifo_empty |=> o_tx_send)
    else $error("Transmitter stopped with data in FIFO");
  a_cfg1_drive: assert property (s_cfg1_write |-> ##2 o_ir_modulation == $past(i_wdata[3:0], 2)
    && o_ir_speed == $past(i_wdata[7:4], 2))
    else $error("Speed or modulation not applied");
  a_second_style_pin: assert property (i_xcvr_second_style |=> !o_low_band_rx_pin)
    else $error("Low band pin driven in second style");
  a_first_style_pins: assert property (!i_xcvr_second_style
    |=> o_low_band_rx_pin != o_high_band_rx_pin)
    else $error("Band pins not exclusive");
  a_chop_off_reset: assert property (disable iff (1'b0) i_sys_rst |=> !o_chop_on)
    else $error("Chopping on after reset");
  a_timer_pending: assert property (s_expire_seen
    |-> tmr_bus.count == 8'h00 ##1 timer_flag)
    else $error("Timer expiry not latched");
  a_fir_masked: assert property (fir_mask |=> !o_fir_irq)
    else $error("Fast request while masked");
  a_bank_decode: assert property (s_read_rfp_lo |=> o_rdata == $past(end_packet_pointer[7:0]))
    else $error("Bank read returned wrong register");
  a_sir_masked: assert property (sir_mask |=> !o_sir_irq)
    else $error("Serial request while masked");
  a_carrier_set: assert property (i_carrier_seen |=> carrier_flag)
    else $error("Carrier detect not latched");
endmodule : fir_bank_regs
`default_nettype wire

// ---- testbench/ir_xcvr_model.sv ----
/*
  Behavioural optical transceiver: one preamble pulse of a set width per
  start request, and one carrier detect pulse at the start of each burst.
  Assumes a single clock shared with the register block.
*/
`timescale 1ns/1ps
`default_nettype none
module ir_xcvr_model (
  input wire logic i_clock,
  input wire logic i_start,
  input wire logic [7:0] i_width,
  input wire logic i_carrier_on,
  output logic o_rx_pulse,
  output logic o_in_preamble,
  output logic o_carrier_seen
);
  logic [8:0] cnt = '0;
  logic active = 1'b0;
  logic carrier_prev = 1'b0;
  // Receive line idles low between frames, as a dark optical path would
  assign o_in_preamble = active;
  assign o_rx_pulse = active && cnt >= 9'd2 && cnt < {1'b0, i_width} + 9'd2;
  // Pulse falls well inside the preamble so the sample edge is always seen
  assign o_carrier_seen = i_carrier_on && !carrier_prev;
  always_ff @(posedge i_clock) begin
    carrier_prev <= i_carrier_on;
    if (i_start) begin
      active <= 1'b1;
      cnt <= '0;
    end else if (active) begin
      cnt <= cnt + 9'd1;
      if (cnt == {1'b0, i_width} + 9'd6) begin
        active <= 1'b0;
      end
    end
  end
endmodule : ir_xcvr_model
`default_nettype wire

// ---- testbench/fir_bank_regs_tb.sv ----
/*
  Self-checking testbench of the banked infrared registers.
  Assumes the defs header, package, interface and design are compiled first.
*/
`include "fir_bank_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fir_bank_regs_tb;
  import fir_bank_pkg::*;
  // Short tick keeps the timer scenario brief
  localparam int tick = 4;
  localparam logic [1:0] b1 = `FIR_BANK_RX;
  localparam logic [1:0] b2 = `FIR_BANK_IR;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [1:0] i_bank = '0;
  logic [2:0] i_addr = '0;
  logic [7:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_rx_eop = 1'b0;
  logic [15:0] i_rx_eop_ptr = '0;
  logic i_tx_enable = 1'b0;
  logic i_tx_byte_taken = 1'b0;
  logic i_tx_fifo_full = 1'b0;
  logic i_tx_fifo_empty = 1'b1;
  logic i_xcvr_second_style = 1'b0;
  logic i_sir_irq_req = 1'b0;
  logic start = 1'b0;
  logic [7:0] width = 8'h10;
  logic carrier_on = 1'b0;
  logic rx_pulse, in_preamble, carrier_seen;
  logic [7:0] o_rdata, o_chop_single_cycles, o_chop_pair_cycles;
  logic [3:0] o_ir_speed, o_ir_modulation;
  logic o_tx_dma_req, o_tx_send, o_low_band_rx_pin, o_high_band_rx_pin;
  logic o_echo, o_chop_on, o_sir_irq, o_fir_irq;
  int n_errors = 0;
  int cmp_count = 0;

  always #4 i_clock = ~i_clock;

  fir_bank_regs #(.TICK_CYCLES(tick)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_bank(i_bank), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rx_eop(i_rx_eop), .i_rx_eop_ptr(i_rx_eop_ptr),
    .i_tx_enable(i_tx_enable), .i_tx_byte_taken(i_tx_byte_taken),
    .i_tx_fifo_full(i_tx_fifo_full), .i_tx_fifo_empty(i_tx_fifo_empty),
    .o_tx_dma_req(o_tx_dma_req), .o_tx_send(o_tx_send), .o_ir_speed(o_ir_speed),
    .o_ir_modulation(o_ir_modulation), .i_xcvr_second_style(i_xcvr_second_style),
    .o_low_band_rx_pin(o_low_band_rx_pin), .o_high_band_rx_pin(o_high_band_rx_pin),
    .o_echo(o_echo), .i_rx_pulse(rx_pulse), .i_in_preamble(in_preamble),
    .o_chop_on(o_chop_on), .o_chop_single_cycles(o_chop_single_cycles),
    .o_chop_pair_cycles(o_chop_pair_cycles), .i_sir_irq_req(i_sir_irq_req),
    .o_sir_irq(o_sir_irq), .i_carrier_seen(carrier_seen), .o_fir_irq(o_fir_irq));

  ir_xcvr_model xcvr (.i_clock(i_clock), .i_start(start), .i_width(width),
    .i_carrier_on(carrier_on), .o_rx_pulse(rx_pulse), .o_in_preamble(in_preamble),
    .o_carrier_seen(carrier_seen));

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic st(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : st

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] b, input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_bank <= b;
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [1:0] b, input logic [2:0] a, input logic [7:0] e,
                      input string m);
    @(posedge i_clock);
    i_bank <= b;
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e, m);
  endtask : rchk

  task automatic t_reset();
    rchk(b1, 3'h4, 8'h00, "pointer low");
    rchk(b1, 3'h5, 8'h00, "pointer high");
    rchk(b2, 3'h2, 8'h00, "transceiver reg");
    rchk(b2, 3'h3, 8'h00, "chop reg");
    chk(o_echo, 1'b0, "echo");
    chk(o_chop_on, 1'b0, "chop on");
    rchk(2'h3, 3'h1, 8'h00, "unmapped bank");
  endtask : t_reset

  task automatic t_pointer();
    @(posedge i_clock);
    i_rx_eop_ptr <= 16'ha5c3;
    i_rx_eop <= 1'b1;
    @(posedge i_clock);
    i_rx_eop <= 1'b0;
    i_rx_eop_ptr <= 16'h0f0f;
    wr(b1, 3'h4, 8'hff);
    rchk(b1, 3'h4, 8'hc3, "pointer low");
    rchk(b1, 3'h5, 8'ha5, "pointer high");
    rchk(b2, 3'h4, 8'h00, "same offset bank 2");
  endtask : t_pointer

  task automatic t_txcount();
    wr(b1, 3'h7, 8'hff);
    rchk(b1, 3'h7, 8'h1f, "count high");
    wr(b1, 3'h7, 8'h00);
    wr(b1, 3'h6, 8'h02);
    @(posedge i_clock);
    i_tx_enable <= 1'b1;
    i_tx_fifo_empty <= 1'b0;
    st(3);
    chk(o_tx_dma_req, 1'b1, "dma with count");
    // Third pulse lands at zero and must not wrap the count
    repeat (3) begin
      @(posedge i_clock);
      i_tx_byte_taken <= 1'b1;
      @(posedge i_clock);
      i_tx_byte_taken <= 1'b0;
    end
    st(3);
    chk(o_tx_dma_req, 1'b0, "dma at zero");
    chk(o_tx_send, 1'b1, "send while fifo holds data");
    rchk(b1, 3'h6, 8'h00, "count low");
    rchk(b1, 3'h7, 8'h00, "count high");
    @(posedge i_clock);
    i_tx_fifo_empty <= 1'b1;
    st(3);
    chk(o_tx_send, 1'b0, "send after drain");
    @(posedge i_clock);
    i_tx_enable <= 1'b0;
  endtask : t_txcount

  task automatic t_config1();
    for (int s = 0; s < 3; s++) begin
      for (int m = 0; m < 5; m++) begin
        wr(b2, 3'h1, {s[3:0], m[3:0]});
        st(3);
        chk(o_ir_speed, s[3:0], "speed");
        chk(o_ir_modulation, m[3:0], "modulation");
      end
    end
    rchk(b2, 3'h1, 8'h24, "config1 readback");
  endtask : t_config1

  task automatic t_xcvr();
    wr(b2, 3'h2, 8'h20);
    st(3);
    chk({o_low_band_rx_pin, o_high_band_rx_pin}, 2'b10, "first style low");
    wr(b2, 3'h2, 8'h10);
    st(3);
    chk({o_low_band_rx_pin, o_high_band_rx_pin}, 2'b01, "first style high");
    @(posedge i_clock);
    i_xcvr_second_style <= 1'b1;
    st(3);
    chk({o_low_band_rx_pin, o_high_band_rx_pin}, 2'b01, "mode bit one");
    wr(b2, 3'h2, 8'h28);
    st(3);
    chk({o_low_band_rx_pin, o_high_band_rx_pin}, 2'b00, "mode bit zero");
    chk(o_echo, 1'b1, "echo on");
    rchk(b2, 3'h2, 8'h28, "transceiver readback");
    wr(b2, 3'h2, 8'h00);
  endtask : t_xcvr

  task automatic t_chop();
    int sgl[3] = '{23, 28, 26};
    int pr[3] = '{27, 32, 29};
    int mg[4] = '{8, 6, 6, 1};
    for (int k = 1; k < 4; k++) begin
      wr(b2, 3'h3, {4'h0, k[1:0], 2'b00});
      st(3);
      chk(o_chop_on, 1'b1, "fixed chop on");
      chk(o_chop_single_cycles, 16'(sgl[k-1]), "fixed single");
      chk(o_chop_pair_cycles, 16'(pr[k-1]), "fixed pair");
    end
    wr(b2, 3'h1, 8'h04);
    for (int k = 4; k < 8; k++) begin
      wr(b2, 3'h3, {1'b1, 3'h0, k[1:0], 2'b00});
      @(posedge i_clock);
      width <= 8'(20 + k);
      start <= 1'b1;
      @(posedge i_clock);
      start <= 1'b0;
      st(40);
      chk(o_chop_single_cycles, 16'(20 + k), "sampled single");
      chk(o_chop_pair_cycles, 16'(20 + k + mg[k-4]), "auto pair");
    end
    wr(b2, 3'h3, 8'h00);
    wr(b2, 3'h1, 8'h00);
    st(3);
    chk(o_chop_on, 1'b0, "chop off");
  endtask : t_chop

  task automatic t_irq();
    @(posedge i_clock);
    i_sir_irq_req <= 1'b1;
    st(3);
    chk(o_sir_irq, 1'b1, "serial request");
    wr(b2, 3'h3, 8'h02);
    st(3);
    chk(o_sir_irq, 1'b0, "serial masked");
    wr(b2, 3'h3, 8'h00);
    @(posedge i_clock);
    i_sir_irq_req <= 1'b0;
    wr(b2, 3'h5, 8'h80);
    @(posedge i_clock);
    carrier_on <= 1'b1;
    @(posedge i_clock);
    carrier_on <= 1'b0;
    st(3);
    chk(o_fir_irq, 1'b1, "carrier request");
    rchk(b2, 3'h5, 8'hc0, "carrier pending");
    wr(b2, 3'h3, 8'h01);
    st(3);
    chk(o_fir_irq, 1'b0, "fast masked");
    wr(b2, 3'h3, 8'h00);
    wr(b2, 3'h5, 8'hc0);
    st(3);
    chk(o_fir_irq, 1'b0, "carrier cleared");
    rchk(b2, 3'h5, 8'h80, "carrier bit clear");
  endtask : t_irq

  task automatic t_timer();
    int n;
    wr(b2, 3'h5, 8'h02);
    wr(b2, 3'h4, 8'h03);
    n = 0;
    while (o_fir_irq !== 1'b1 && n < 200) begin
      st(1);
      n++;
    end
    if (n == 200) begin
      n_errors++;
      $display("mismatch at %0t: timer never expired", $time);
      return;
    end
    chk(16'(n > 2 * tick && n <= 4 * tick + 2), 16'h1, "timer period");
    rchk(b2, 3'h5, 8'h03, "timer pending");
    rchk(b2, 3'h4, 8'h03, "timer value");
    wr(b2, 3'h5, 8'h03);
    rchk(b2, 3'h5, 8'h02, "timer cleared");
    st(2);
    chk(o_fir_irq, 1'b0, "no request left");
  endtask : t_timer

  initial begin
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset();
    t_pointer();
    t_txcount();
    t_config1();
    t_xcvr();
    t_chop();
    t_irq();
    t_timer();
    complete_run();
  end
endmodule : fir_bank_regs_tb
`default_nettype wire
